// ==== ursmp_pkg.sv ====
/*
  Package for the receive bit sampler: timing constants, modes and carriers.
  Assumes a single component clock; each tick of it is one oversampling clock.
*/
`default_nettype none
package ursmp_pkg;

  // Oversampling factors
  localparam int unsigned OVS_8X = 8;
  localparam int unsigned OVS_16X = 16;

  // Sample point, in oversampling clocks after the counter restart (8x / 16x)
  localparam logic [3:0] SAMPLE_PT_8X = 4'h3;
  localparam logic [3:0] SAMPLE_PT_16X = 4'h7;

  // Bits per frame: start, eight data, one stop
  localparam int unsigned DATA_BITS = 8;
  localparam logic [3:0] FRAME_BITS = 4'hA;

  // Reset values
  localparam logic [3:0] OVS_CNT_RST = 4'h0;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [7:0] DATA_RST = 8'h00;

  // Oversampling selection
  typedef enum logic
  {
    URSMP_OVS_8 = 1'b0,
    URSMP_OVS_16 = 1'b1
  } ursmp_ovs_e;

  // Run-time configuration
  typedef struct packed
  {
    ursmp_ovs_e ovs;  // Oversampling factor
    logic vote_en;    // 2-of-3 voting around each sample point
  } ursmp_cfg_s;

  // Received frame result
  typedef struct packed
  {
    logic [7:0] data;     // Data bits, first received in bit 0
    logic frame_err;      // Stop bit sampled low
  } ursmp_frame_s;

  // Receiver states, one-hot
  typedef enum logic [2:0]
  {
    URSMP_IDLE = 3'b001,
    URSMP_RUN = 3'b010,
    URSMP_DONE = 3'b100
  } ursmp_state_e;

endpackage : ursmp_pkg
`default_nettype wire

// ==== ursmp_rx.sv ====
/*
  Receive-side bit sampler of an asynchronous serial receiver.
  Assumes rx_line comes from a pin (asynchronous) and clk is the oversampling
  clock itself, so the bit period is 8 or 16 clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module ursmp_rx
  import ursmp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire ursmp_cfg_s cfg,
  input wire logic rx_line,
  output ursmp_frame_s frame,
  output logic frame_valid,
  output logic busy,
  output logic sample_strobe
);

  // Synchroniser: three flops, change accepted when second and third agree
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic rx_filt_r;        // Filtered line level
  logic rx_filt_d_r;      // Previous filtered level, for edge detection
  logic [2:0] vote_r;     // Last three filtered levels for voting

  // Frame timing state
  ursmp_state_e state_r;
  logic [3:0] ovs_cnt_r;  // Oversampling clock within a bit
  logic [3:0] bit_cnt_r;  // Bit index within the frame
  logic [7:0] shift_r;    // Assembled data bits
  logic frame_err_r;
  logic frame_valid_r;
  logic strobe_r;
  logic vote_pending_r;   // Voting needs one more clock after the sample point
  logic busy_r;           // Frame in progress; a flop of its own so the port is registered

  // Per-mode constants
  logic [3:0] last_cnt;   // Last count of a bit period
  logic [3:0] sample_pt;  // Count at which the bit is taken
  logic fall_edge;
  logic voted;
  logic bit_val;
  logic take_bit;

  // Mode decode: period of 8 or 16 clocks
  always_comb
  begin
    if (cfg.ovs == URSMP_OVS_16)
    begin
      last_cnt = 4'(OVS_16X - 1);
      sample_pt = SAMPLE_PT_16X;
    end
    else
    begin
      last_cnt = 4'(OVS_8X - 1);
      sample_pt = SAMPLE_PT_8X;
    end
  end

  // Synchroniser chain; only the second flop reads the first
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      sync3_r <= 1'b1;
    end
    else
    begin
      sync1_r <= rx_line;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Filtered level moves only once second and third stages agree
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rx_filt_r <= 1'b1;
      rx_filt_d_r <= 1'b1;
      vote_r <= 3'h7;
    end
    else
    begin
      if (sync2_r == sync3_r)
      begin
        rx_filt_r <= sync3_r;
      end
      rx_filt_d_r <= rx_filt_r;
      vote_r <= {vote_r[1:0], rx_filt_r};
    end
  end

  // Idle-high line dropping low marks a start bit
  assign fall_edge = rx_filt_d_r & ~rx_filt_r;

  // Majority of sample point and one clock either side; vote_r[0] is the
  // sample-point level once the following clock has also been captured
  assign voted = (vote_r[0] & vote_r[1]) | (vote_r[0] & rx_filt_r) | (vote_r[1] & rx_filt_r);

  // Without voting the bit is the level at the sample point itself
  assign take_bit = cfg.vote_en ? vote_pending_r : (state_r == URSMP_RUN && ovs_cnt_r == sample_pt);
  assign bit_val = cfg.vote_en ? voted : rx_filt_r;

  // Frame sequencer
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_r <= URSMP_IDLE;
      ovs_cnt_r <= OVS_CNT_RST;
      bit_cnt_r <= BIT_CNT_RST;
      vote_pending_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      // Voting result is one clock after the sample point
      vote_pending_r <= cfg.vote_en && state_r == URSMP_RUN && ovs_cnt_r == sample_pt;
      unique case (state_r)
        URSMP_IDLE:
        begin
          if (fall_edge)
          begin
            // Counters cleared; counting starts on the next edge
            ovs_cnt_r <= OVS_CNT_RST;
            bit_cnt_r <= BIT_CNT_RST;
            state_r <= URSMP_RUN;
            busy_r <= 1'b1;
          end
        end
        URSMP_RUN:
        begin
          // Wrap every period so each midpoint follows the last by one bit
          if (ovs_cnt_r == last_cnt)
          begin
            ovs_cnt_r <= OVS_CNT_RST;
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          else
          begin
            ovs_cnt_r <= ovs_cnt_r + 4'h1;
          end
          // Stop bit taken at 9.5 bit periods; leave without waiting out the
          // rest of the stop bit so a quick next start edge is seen
          if (take_bit && bit_cnt_r == FRAME_BITS - 4'h1)
          begin
            state_r <= URSMP_DONE;
          end
          // A start bit that is high at its midpoint was a glitch
          else if (take_bit && bit_cnt_r == BIT_CNT_RST && bit_val)
          begin
            state_r <= URSMP_IDLE;
            busy_r <= 1'b0;
          end
        end
        URSMP_DONE:
        begin
          // One clock to publish the frame. With voting on and a fast sender,
          // the late sample can overlap the next start; two stop bits avoid it
          state_r <= URSMP_IDLE;
          busy_r <= 1'b0;
        end
        default:
        begin
          state_r <= URSMP_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  // Data capture and frame status
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      shift_r <= DATA_RST;
      frame_err_r <= 1'b0;
      frame_valid_r <= 1'b0;
      strobe_r <= 1'b0;
    end
    else
    begin
      strobe_r <= take_bit && state_r == URSMP_RUN;
      frame_valid_r <= 1'b0;
      if (take_bit && state_r == URSMP_RUN)
      begin
        if (bit_cnt_r == FRAME_BITS - 4'h1)
        begin
          frame_err_r <= ~bit_val;
          frame_valid_r <= 1'b1;
        end
        else if (bit_cnt_r != BIT_CNT_RST)
        begin
          // LSB first: shift in from the top
          shift_r <= {bit_val, shift_r[7:1]};
        end
      end
    end
  end

  // Registered outputs
  always_comb
  begin
    frame.data = shift_r;
    frame.frame_err = frame_err_r;
    frame_valid = frame_valid_r;
    sample_strobe = strobe_r;
    busy = busy_r;
  end

endmodule : ursmp_rx
`default_nettype wire

// ==== ursmp_rx_asserts.sv ====
/* Port checker for the receive bit sampler.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module ursmp_rx_asserts
  import ursmp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire ursmp_cfg_s cfg,
  input wire logic rx_line,
  input wire ursmp_frame_s frame,
  input wire logic frame_valid,
  input wire logic busy,
  input wire logic sample_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Plain timing; voting adds a decision clock
  logic p8;
  logic p16;
  assign p8 = cfg.ovs == URSMP_OVS_8 && !cfg.vote_en;
  assign p16 = cfg.ovs == URSMP_OVS_16 && !cfg.vote_en;
  // Frame launch as seen on busy
  sequence go8;
    $rose(busy) && p8;
  endsequence
  sequence go16;
    $rose(busy) && p16;
  endsequence
  first_8x_a: assert property (go8 |-> ##4 sample_strobe) else $error("8x first late");
  first_16x_a: assert property (go16 |-> ##8 sample_strobe) else $error("16x first late");
  step_8x_a: assert property (sample_strobe && p8 && !frame_valid |-> ##8 sample_strobe || !busy) else $error("8x step");
  step_16x_a: assert property (sample_strobe && p16 && !frame_valid |-> ##16 sample_strobe || !busy) else $error("16x step");
  stop_8x_a: assert property (frame_valid && p8 |-> $past(busy, 76) && !$past(busy, 77)) else $error("8x stop");
  stop_16x_a: assert property (frame_valid && p16 |-> $past(busy, 152) && !$past(busy, 153)) else $error("16x stop");
  // The pin was high, then low for two clocks, before the frame started; it may rise again later (false start)
  start_low_a: assert property ($rose(busy) |-> $past(rx_line, 6) && !$past(rx_line, 5) && !$past(rx_line, 4)) else $error("start edge");
  vote_first_a: assert property ($rose(busy) && cfg.vote_en |-> ##[5:9] sample_strobe) else $error("vote late");
endmodule : ursmp_rx_asserts
`default_nettype wire

// ==== ursmp_tx_model.sv ====
/* Remote transmitter model driving the receive line.
   Assumes send is called between frames; line idles high. */
`timescale 1ns/1ps
`default_nettype none
module ursmp_tx_model
  import ursmp_pkg::*;
(
  input wire logic clk,
  input wire ursmp_ovs_e ovs,
  output var logic line
);
  // Idle level
  initial line = 1'b1;
  // Start, data first bit 0, two stop bits; g flips one mid clock of each data bit
  task automatic send(input logic [7:0] d, input logic g);
    logic [10:0] f;
    int per;
    f = {2'b11, d, 1'b0};
    per = (ovs == URSMP_OVS_16) ? 16 : 8;
    for (int i = 0; i < 11; i++)
      for (int k = 0; k < per; k++)
      begin
        @(negedge clk);
        line = (g && i > 0 && i < 9 && k == per / 2) ? !f[i] : f[i];
      end
  endtask : send
  // Line low for n clocks, then idle: a short dip is a false start, a long one a break
  task automatic low(input int n);
    for (int k = 0; k < n; k++)
    begin
      @(negedge clk);
      line = 1'b0;
    end
    @(negedge clk);
    line = 1'b1;
  endtask : low
endmodule : ursmp_tx_model
`default_nettype wire

// ==== ursmp_rx_bit_sampler_test.sv ====
/* Self-checking bench for the receive bit sampler.
   Assumes the model owns rx_line; inputs change at falling edges. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin fail_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module ursmp_rx_bit_sampler_test
  import ursmp_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  ursmp_cfg_s cfg = '{URSMP_OVS_8, 1'b0};
  logic rx_line;
  ursmp_frame_s frame;
  ursmp_frame_s got;
  logic frame_valid;
  logic busy;
  logic sample_strobe;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n_str = 0;
  int n_val = 0;
  // 200 MHz clock
  initial forever #2.5 clk = ~clk;
  ursmp_tx_model tx (.clk(clk), .ovs(cfg.ovs), .line(rx_line));
  ursmp_rx dut (.clk(clk), .resetn(resetn), .cfg(cfg), .rx_line(rx_line), .frame(frame),
    .frame_valid(frame_valid), .busy(busy), .sample_strobe(sample_strobe));
  // Count strobes, catch frames, cut a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (sample_strobe) n_str++;
    if (frame_valid)
    begin
      n_val++;
      got = frame;
    end
    if (cyc == 20000)
    begin
      fail_count++;
      final_report();
    end
  end
  // One frame, then judge it; cfg moves only while idle and settles a clock
  // before the model reads the mode, so the bit period never uses the old one
  task automatic run(input ursmp_ovs_e o, input logic v, input logic [7:0] d, input logic g);
    @(negedge clk);
    cfg = '{o, v};
    n_str = 0;
    n_val = 0;
    @(negedge clk);
    tx.send(d, g);
    repeat (4) @(negedge clk);
    `CHK("valid", 1, n_val)
    `CHK("strobes", 10, n_str)
    `CHK("data", d, got.data)
    `CHK("stop", 1'b0, got.frame_err)
  endtask : run
  // 8x alternating and all-zeros bytes, each after an idle gap
  task automatic sc_8x;
    run(URSMP_OVS_8, 1'b0, 8'hA5, 1'b0);
    run(URSMP_OVS_8, 1'b0, 8'h00, 1'b0);
  endtask : sc_8x
  // 16x alternating and all-ones bytes
  task automatic sc_16x;
    run(URSMP_OVS_16, 1'b0, 8'h5A, 1'b0);
    run(URSMP_OVS_16, 1'b0, 8'hFF, 1'b0);
  endtask : sc_16x
  // Voting on with a one-clock glitch per data bit; the synchroniser filter drops it before the vote
  task automatic sc_vote;
    run(URSMP_OVS_8, 1'b1, 8'h3C, 1'b1);
    run(URSMP_OVS_16, 1'b1, 8'hC3, 1'b1);
  endtask : sc_vote
  // Line low through the stop bit: zero data with a framing error
  task automatic sc_break;
    @(negedge clk);
    cfg = '{URSMP_OVS_8, 1'b0};
    n_str = 0;
    n_val = 0;
    @(negedge clk);
    tx.low(88);
    repeat (8) @(negedge clk);
    `CHK("break valid", 1, n_val)
    `CHK("break strobes", 10, n_str)
    `CHK("break data", 8'h00, got.data)
    `CHK("break stop", 1'b1, got.frame_err)
  endtask : sc_break
  // A three-clock dip is high again at the start midpoint: one strobe, no frame
  task automatic sc_false;
    n_str = 0;
    n_val = 0;
    tx.low(3);
    repeat (12) @(negedge clk);
    `CHK("false valid", 0, n_val)
    `CHK("false strobes", 1, n_str)
    `CHK("false busy", 1'b0, busy)
  endtask : sc_false
  task automatic final_report;
    $display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  // Reset two cycles, let the line settle high
  initial
  begin
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (6) @(negedge clk);
    sc_8x();
    sc_16x();
    sc_vote();
    sc_break();
    sc_false();
    final_report();
  end
endmodule : ursmp_rx_bit_sampler_test
bind ursmp_rx ursmp_rx_asserts chk (.clk(clk), .resetn(resetn), .cfg(cfg), .rx_line(rx_line), .frame(frame),
  .frame_valid(frame_valid), .busy(busy), .sample_strobe(sample_strobe));
`default_nettype wire
